/* File: audio_route_consts.svh */
// register offsets, reset values, rate limits and timing counts of the audio route block
// assumes a 10 MHz reference clock and an APB register bus
`ifndef AUDIO_ROUTE_CONSTS_SVH
`define AUDIO_ROUTE_CONSTS_SVH

`define CLK_HZ            10000000
`define STATUS_PERIOD_MS  500
`define STATUS_PERIOD_CYC ((`CLK_HZ / 1000) * `STATUS_PERIOD_MS)

`define OFF_CTRL          12'h000
`define OFF_TRACK         12'h004
`define OFF_VOLUME        12'h008
`define OFF_STATUS        12'h00C
`define OFF_RATE          12'h010

`define CTRL_RESET        32'h00000000
`define TRACK_RESET       2'h0
`define COARSE_RESET      2'h0
`define FINE_RESET        6'h00

`define RATE_MIN_HZ       25000
`define RATE_MAX_HZ       102000
`define RATE_TOL_HZ       500
`define RATE_BITS         17

`endif

/* File: audio_route_pkg.sv */
// types shared by the audio route block
package audio_route_pkg;

  typedef enum logic [1:0]
  {
    MON_AUTO  = 2'b00,
    MON_PLAY  = 2'b01,
    MON_INPUT = 2'b10
  } mon_mode_e;

  typedef enum logic [1:0]
  {
    CLK_AUTO   = 2'b00,
    CLK_MASTER = 2'b01,
    CLK_WORD   = 2'b10
  } clk_mode_e;

  typedef enum logic [1:0]
  {
    SRC_CRYSTAL = 2'b00,
    SRC_INPUT   = 2'b01,
    SRC_WORD    = 2'b10
  } clk_src_e;

  typedef struct packed
  {
    mon_mode_e  mon_mode;
    clk_mode_e  clk_mode;
    logic       force_multi;
    logic       multi_to_stereo;
  } ctrl_s;

  typedef struct packed
  {
    logic        no_lock;
    logic        rate_unknown;
    logic        input_multi;
    logic [16:0] rate_hz;
  } in_status_s;

  typedef logic [23:0] sample_t;

endpackage

/* File: rate_classify.sv */
// classifies a measured input rate against the standard rates
// assumes a measured rate in hertz from logic on the same clock
`timescale 1ns/10ps
`include "audio_route_consts.svh"

module rate_classify
  import audio_route_pkg::*;
(
  input  wire logic [16:0] rate_hz,
  input  wire logic [16:0] ref_hz,
  output logic             in_range,
  output logic             standard,
  output logic             rate_match
);

  localparam int NSTD = 6;
  localparam logic [16:0] STD [NSTD] = '{17'd32000, 17'd44100, 17'd48000, 17'd64000, 17'd88200, 17'd96000};
  localparam logic [16:0] TOL = 17'(`RATE_TOL_HZ);

  logic [NSTD-1:0] hit;

  function automatic logic near(input logic [16:0] a, input logic [16:0] b);
    logic [16:0] d;
    d = (a > b) ? a - b : b - a;
    near = (d <= TOL);
  endfunction

  genvar i;
  generate
    for (i = 0; i < NSTD; i = i + 1)
    begin : g_std
      assign hit[i] = near(rate_hz, STD[i]);
    end
  endgenerate

  assign in_range   = (rate_hz >= 17'(`RATE_MIN_HZ)) && (rate_hz <= 17'(`RATE_MAX_HZ));
  assign standard   = |hit;
  // same, double or half of the playback rate
  // double compared as half of the input, so no bit of the reference is lost
  assign rate_match = near(rate_hz, ref_hz) || near({1'b0, rate_hz[16:1]}, ref_hz)
                      || near(rate_hz, {1'b0, ref_hz[16:1]});

endmodule

/* File: attenuator.sv */
// applies coarse 6 dB steps and a fine gain to one channel
// assumes samples and settings on the same clock
`timescale 1ns/10ps

module attenuator
  import audio_route_pkg::*;
(
  input  wire logic    [1:0] coarse,
  input  wire logic    [5:0] fine,
  input  wire sample_t       din,
  output sample_t            dout
);

  logic signed [23:0] shifted;
  logic signed [30:0] prod;

  assign shifted = $signed(din) >>> coarse;
  // fine scales by (64 - fine)/64
  assign prod    = shifted * $signed({1'b0, 6'd63 - fine + 6'd1 == 6'd0 ? 7'd64 : 7'(7'd64 - {1'b0, fine})});
  assign dout    = sample_t'(prod >>> 6);

endmodule

/* File: audio_route_clock_select.sv */
// monitoring routing, output format and sample clock selection of the audio card
// assumes APB on ref_clk; link strobes and samples already on ref_clk; jumper and lock pins asynchronous
// Functional notes
// - input rate and format status refresh every half second.
// - loss of lock reported on errored input or missing signal.
// - unknown rate reported in vari-speed or when far from any standard rate.
// - stereo format for two-channel input, multichannel flag for eight-channel input.
// - automatic mode passes input to outputs only while recording.
// - playback-only mode never passes input to outputs.
// - input mode passes input whenever playback is inactive, no software needed.
// - eight-channel output feeds analog from track-selected channel pair.
// - analog attenuation is coarse 6 dB steps plus fine, both applied.
// - force-multichannel drives output in eight-channel format unless the conversion setting is on.
// - eight-channel input delivers channels 1 and 2 as stereo record.
// - forced multichannel stereo playback lands on tracks 1 and 2.
// - forced multichannel pass-through copies stereo input to all four pairs.
// - conversion setting forces stereo output from track-selected input pair.
// - before host setup, boot jumper picks eight-channel, else stereo.
// - auto clock follows valid matching input, reports master or slave.
// - master mode always runs from the crystal.
// - synchronises to same, double or half rate input.
// - follows source between 25 and 102 kHz immediately once running.
// - word clock mode uses word clock input within same range.
// - every setting takes effect as soon as written.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "audio_route_consts.svh"

module audio_route_clock_select
  import audio_route_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               boot_format_jumper,
  input  wire logic               in_lock,
  input  wire logic               in_error,
  input  wire logic               in_is_multi,
  input  wire logic               word_lock,
  input  wire logic               recording,
  input  wire logic               playing,
  input  wire logic               play_multi,
  input  wire logic [16:0]        in_rate_hz,
  input  wire logic [16:0]        word_rate_hz,
  input  wire logic [16:0]        play_rate_hz,
  input  wire logic               frame_stb,
  input  wire sample_t            in_ch   [8],
  input  wire sample_t            play_ch [8],
  output sample_t                 out_ch  [8],
  output sample_t                 rec_left,
  output sample_t                 rec_right,
  output sample_t                 ana_left,
  output sample_t                 ana_right,
  output logic                    out_multi,
  output logic                    monitor_on,
  output clk_src_e                clk_src
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [1:0]  pin_s1;
  logic [1:0]  pin_s2;
  logic [2:0]  lck_s1;
  logic [2:0]  lck_s2;
  logic        host_init;
  logic        boot_multi;
  logic        boot_taken;
  ctrl_s       ctrl;
  logic [1:0]  track;
  logic [1:0]  coarse;
  logic [5:0]  fine;
  in_status_s  status;
  logic [22:0] tick_cnt;
  logic        following;
  sample_t     mon_ch [8];
  sample_t     att_l;
  sample_t     att_r;

  wire jumper_s  = pin_s2[0];
  wire in_lock_s = lck_s2[0];
  wire in_err_s  = lck_s2[1];
  wire word_lk_s = lck_s2[2];
  wire multi_s   = pin_s2[1];

  // reset release and pin synchronisers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync <= 2'h0;
      pin_s1   <= 2'h0;
      pin_s2   <= 2'h0;
      lck_s1   <= 3'h0;
      lck_s2   <= 3'h0;
    end
    else if (clk_en)
    begin
      rst_sync <= {rst_sync[0], 1'b1};
      pin_s1   <= {in_is_multi, boot_format_jumper};
      pin_s2   <= pin_s1;
      lck_s1   <= {word_lock, in_error, in_lock};
      lck_s2   <= lck_s1;
    end
  end
  assign rst_n = rst_sync[1];

  // apb decode
  wire apb_wr  = psel && penable && pwrite;
  wire apb_rd  = psel && !penable && !pwrite;
  wire hit_ctl = paddr == `OFF_CTRL;
  wire hit_trk = paddr == `OFF_TRACK;
  wire hit_vol = paddr == `OFF_VOLUME;
  wire hit_sts = paddr == `OFF_STATUS;
  wire hit_rat = paddr == `OFF_RATE;
  wire mapped  = hit_ctl || hit_trk || hit_vol || hit_sts || hit_rat;
  wire bad_wr  = hit_sts || hit_rat || !mapped;

  wire [31:0] rd_word =
      hit_ctl ? {25'h0, host_init, ctrl.multi_to_stereo, ctrl.force_multi, ctrl.clk_mode, ctrl.mon_mode} :
      hit_trk ? {30'h0, track} :
      hit_vol ? {24'h0, coarse, fine} :
      hit_sts ? {26'h0, out_multi, clk_src, status.input_multi, status.rate_unknown, status.no_lock} :
      hit_rat ? {15'h0, status.rate_hz} : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (pwrite ? bad_wr : !mapped);
      if (apb_rd)
      begin
        prdata <= rd_word;
      end
    end
  end

  // control registers; writes take effect at once
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl      <= ctrl_s'(`CTRL_RESET);
      track     <= `TRACK_RESET;
      coarse    <= `COARSE_RESET;
      fine      <= `FINE_RESET;
      host_init <= 1'b0;
    end
    else if (clk_en && apb_wr && pready)
    begin
      if (hit_ctl)
      begin
        ctrl      <= ctrl_s'({pwdata[1:0], pwdata[3:2], pwdata[4], pwdata[5]});
        host_init <= 1'b1;
      end
      if (hit_trk)
      begin
        track <= pwdata[1:0];
      end
      if (hit_vol)
      begin
        coarse <= pwdata[7:6];
        fine   <= pwdata[5:0];
      end
    end
  end

  // boot strap caught after release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_multi <= 1'b0;
      boot_taken <= 1'b0;
    end
    else if (clk_en && !boot_taken)
    begin
      boot_multi <= jumper_s;
      boot_taken <= 1'b1;
    end
  end

  // half second status refresh
  wire tick = tick_cnt == 23'(`STATUS_PERIOD_CYC - 1);
  wire in_range;
  wire in_std;
  wire in_match;
  wire wc_range;
  wire wc_std;
  wire wc_match;

  rate_classify u_in_rate
  (
    .rate_hz    (in_rate_hz),
    .ref_hz     (play_rate_hz),
    .in_range   (in_range),
    .standard   (in_std),
    .rate_match (in_match)
  );

  rate_classify u_wc_rate
  (
    .rate_hz    (word_rate_hz),
    .ref_hz     (play_rate_hz),
    .in_range   (wc_range),
    .standard   (wc_std),
    .rate_match (wc_match)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 23'h0;
      status   <= '0;
    end
    else if (clk_en)
    begin
      tick_cnt <= tick ? 23'h0 : tick_cnt + 23'h1;
      if (tick)
      begin
        status.no_lock      <= !in_lock_s || in_err_s;
        status.rate_unknown <= !in_std;
        status.input_multi  <= multi_s;
        status.rate_hz      <= in_rate_hz;
      end
    end
  end

  // clock source selection
  wire in_valid  = in_lock_s && !in_err_s;
  wire can_start = in_valid && in_match && in_std;
  wire keep_on   = in_valid && in_range;
  wire next_following = following ? keep_on : can_start;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      following <= 1'b0;
      clk_src   <= SRC_CRYSTAL;
    end
    else if (clk_en)
    begin
      following <= (ctrl.clk_mode == CLK_AUTO) && next_following;
      unique case (ctrl.clk_mode)
        CLK_AUTO:   clk_src <= next_following ? SRC_INPUT : SRC_CRYSTAL;
        CLK_MASTER: clk_src <= SRC_CRYSTAL;
        CLK_WORD:   clk_src <= (word_lk_s && wc_range) ? SRC_WORD : SRC_CRYSTAL;
        default:    clk_src <= SRC_CRYSTAL;
      endcase
    end
  end

  // monitoring and format routing
  wire mon_sel =
      (ctrl.mon_mode == MON_AUTO)  ? recording :
      (ctrl.mon_mode == MON_INPUT) ? !playing :
      1'b0;
  wire fmt_multi = !host_init ? boot_multi :
      ctrl.multi_to_stereo ? 1'b0 :
      (ctrl.force_multi || play_multi || (mon_sel && multi_s && !ctrl.multi_to_stereo));
  wire stereo_src_multi = multi_s && ctrl.multi_to_stereo;

  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1)
    begin : g_ch
      // stereo input copied to every pair; multichannel input passed straight, or track-selected pair chosen when converting
      wire sample_t in_pick = !multi_s ? in_ch[p % 2] :
                              stereo_src_multi ? in_ch[{track, 1'b0} + (p % 2)] : in_ch[p];
      wire sample_t pl_pick = play_multi ? play_ch[p] : ((p < 2) ? play_ch[p] : 24'h0);
      assign mon_ch[p] = mon_sel ? in_pick : pl_pick;
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          out_ch[p] <= 24'h0;
        end
        else if (clk_en && frame_stb)
        begin
          out_ch[p] <= (fmt_multi || p < 2) ? mon_ch[p] : 24'h0;
        end
      end
    end
  endgenerate

  wire sample_t ana_src_l = fmt_multi ? mon_ch[{track, 1'b0}] : mon_ch[0];
  wire sample_t ana_src_r = fmt_multi ? mon_ch[{track, 1'b1}] : mon_ch[1];

  attenuator u_att_l
  (
    .coarse (coarse),
    .fine   (fine),
    .din    (ana_src_l),
    .dout   (att_l)
  );

  attenuator u_att_r
  (
    .coarse (coarse),
    .fine   (fine),
    .din    (ana_src_r),
    .dout   (att_r)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rec_left   <= 24'h0;
      rec_right  <= 24'h0;
      ana_left   <= 24'h0;
      ana_right  <= 24'h0;
      out_multi  <= 1'b0;
      monitor_on <= 1'b0;
    end
    else if (clk_en)
    begin
      out_multi  <= fmt_multi;
      monitor_on <= mon_sel;
      if (frame_stb)
      begin
        rec_left  <= in_ch[0];
        rec_right <= in_ch[1];
        ana_left  <= att_l;
        ana_right <= att_r;
      end
    end
  end

endmodule

/* File: audio_route_chk.sv */
// concurrent checks on the audio route block ports
// assumes one ref_clk domain and clk_en held high
`timescale 1ns/10ps
`include "audio_route_consts.svh"

module audio_route_chk
  import audio_route_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        boot_format_jumper,
  input wire logic        in_is_multi,
  input wire logic        recording,
  input wire logic        frame_stb,
  input wire sample_t     in_ch [8],
  input wire sample_t     out_ch [8],
  input wire sample_t     rec_left,
  input wire sample_t     rec_right,
  input wire logic        out_multi,
  input wire logic        monitor_on,
  input wire clk_src_e    clk_src
);
  logic [5:0] ctl;
  logic       wr;
  logic [2:0] age;
  wire        ok = age == 3'h7;
  wire        ctl_wr = psel && penable && pready && pwrite && paddr == `OFF_CTRL;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // shadow control word, cycles since reset or last control write
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      ctl <= 6'h00;
      wr  <= 1'b0;
      age <= 3'h0;
    end
    else
    begin
      ctl <= ctl_wr ? pwdata[5:0] : ctl;
      wr  <= wr | ctl_wr;
      age <= ctl_wr ? 3'h0 : ok ? age : age + 3'h1;
    end

  a_access_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase length wrong");
  a_refused_err: assert property (pready && (paddr > `OFF_RATE || pwrite && paddr >= `OFF_STATUS) |-> pslverr)
    else $error("refused access without error");
  a_play_no_mon: assert property (ok && ctl[1:0] == MON_PLAY |-> !monitor_on)
    else $error("input routed in play-only mode");
  a_auto_rec_mon: assert property ((ok && ctl[1:0] == MON_AUTO && recording)[*3] |-> monitor_on)
    else $error("no monitoring while recording");
  a_master_xtal: assert property (ok && ctl[3:2] == CLK_MASTER |-> clk_src == SRC_CRYSTAL)
    else $error("master mode left the crystal");
  a_force_multi: assert property (ok && wr && ctl[4] && !ctl[5] |-> out_multi)
    else $error("forced multichannel not applied");
  a_boot_format: assert property (ok && !wr |-> out_multi == boot_format_jumper)
    else $error("boot format differs from jumper");
  a_rec_pair: assert property (ok && frame_stb |=> rec_left == $past(in_ch[0]) && rec_right == $past(in_ch[1]))
    else $error("record pair not input channels 0 and 1");
  a_dup_pairs: assert property (ok && ctl[1:0] == MON_INPUT && ctl[4] && !ctl[5] && !$past(in_is_multi, 2)
    && monitor_on && frame_stb
    |=> out_ch[6] == $past(in_ch[0]) && out_ch[7] == $past(in_ch[1]))
    else $error("stereo input not copied to last pair");
endmodule

/* File: audio_source.sv */
// far-side digital audio source: lock, rate and frames
// assumes the bench clock; one frame every 8 cycles
`timescale 1ns/10ps

module audio_source
  import audio_route_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        alive,
  input  wire logic        multi,
  input  wire logic [16:0] rate,
  output logic             in_lock,
  output logic             in_error,
  output logic             in_is_multi,
  output logic [16:0]      in_rate_hz,
  output logic             frame_stb,
  output sample_t          in_ch [8]
);
  logic [2:0]  cnt = 3'h0;
  logic [20:0] num = 21'h000000;

  initial {in_lock, in_error, in_is_multi, frame_stb, in_rate_hz} = '0;
  initial in_ch = '{default: '0};

  // silent source: no lock, rate wanders
  always @(posedge ref_clk)
  begin
    cnt         <= cnt + 3'h1;
    frame_stb   <= cnt == 3'h7;
    in_lock     <= alive;
    in_error    <= !alive;
    in_is_multi <= alive && multi;
    in_rate_hz  <= alive ? rate : in_rate_hz ^ 17'h1FFFF;
    if (cnt == 3'h7)
    begin
      num <= num + 21'h000001;
      for (int k = 0; k < 8; k++)
        in_ch[k] <= {k[2:0], num};
    end
  end
endmodule

/* File: audio_route_clock_select_bench.sv */
// self-checking bench of the audio route block
// assumes design, checker and source model compiled before it
`timescale 1ns/10ps
`include "audio_route_consts.svh"

module audio_route_clock_select_bench
  import audio_route_pkg::*;
  ;
  logic        ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h0000005C;
  logic        pready, pslverr, out_multi, monitor_on, boot_format_jumper = 1'b1, word_lock = 1'b0;
  logic        in_lock, in_error, in_is_multi, frame_stb, alive = 1'b0, multi = 1'b0;
  logic        recording = 1'b0, playing = 1'b0, play_multi = 1'b0;
  logic [16:0] in_rate_hz, rate = 17'h0BB80, word_rate_hz = 17'h0BB80, play_rate_hz = 17'h0BB80;
  sample_t     in_ch [8], play_ch [8] = '{default: '0}, out_ch [8], isnap [8], psnap [8];
  sample_t     rec_left, rec_right, ana_left, ana_right;
  clk_src_e    clk_src;
  logic [33:0] q [$];
  int          n_mismatch = 0, tests_run = 0;

  audio_route_clock_select dut_u (.ref_clk, .resetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .boot_format_jumper, .in_lock, .in_error, .in_is_multi, .word_lock,
    .recording, .playing, .play_multi, .in_rate_hz, .word_rate_hz, .play_rate_hz, .frame_stb, .in_ch,
    .play_ch, .out_ch, .rec_left, .rec_right, .ana_left, .ana_right, .out_multi, .monitor_on, .clk_src);
  audio_source src_u (.ref_clk, .alive, .multi, .rate, .in_lock, .in_error, .in_is_multi, .in_rate_hz,
    .frame_stb, .in_ch);

  always #50 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // coarse 6 dB shifts, then scale by (64 - fine)/64
  function automatic logic [23:0] att(input logic [23:0] s, input logic [7:0] g);
    int x;
    x = $signed(s);
    x = (x >>> g[7:6]) * (64 - int'(g[5:0]));
    return 24'(x >>> 6);
  endfunction

  always @(posedge ref_clk)
  begin
    rs <= lfsr(rs);
    for (int k = 0; k < 8; k++)
      play_ch[k] <= sample_t'(rs >> k);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] e);
    int i;
    q.push_back({w, err, e});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    @(posedge ref_clk);
  endtask

  // completed transfer against oldest note
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && q.size() > 0)
    begin
      chk("pslverr", 32'(q[0][32]), 32'(pslverr));
      if (!q[0][33])
        chk("prdata", q[0][31:0], prdata);
      void'(q.pop_front());
    end

  task automatic frame;
    int i;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (frame_stb !== 1'b1 && i < 20);
    if (frame_stb !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    isnap = in_ch;
    psnap = play_ch;
    @(posedge ref_clk);
  endtask

  task automatic wsrc(input clk_src_e e);
    int i;
    i = 0;
    while (clk_src !== e && i < 200)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk("clk_src", 32'(e), 32'(clk_src));
    if (clk_src !== e)
      complete_run();
  endtask

  task automatic reset_cycle(input logic j);
    resetn             <= 1'b0;
    boot_format_jumper <= j;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("out_multi", 32'(j), 32'(out_multi));
    $display("test reset done");
  endtask

  initial
  begin
    logic [31:0] v;
    reset_cycle(1'b1);
    apb(1'b0, `OFF_CTRL, 32'h0, 1'b0, `CTRL_RESET);
    apb(1'b0, `OFF_TRACK, 32'h0, 1'b0, 32'(`TRACK_RESET));
    apb(1'b0, `OFF_STATUS, 32'h0, 1'b0, 32'h00000020);
    apb(1'b0, `OFF_RATE, 32'h0, 1'b0, 32'h0);
    v = rs;
    apb(1'b1, `OFF_VOLUME, v, 1'b0, 32'h0);
    apb(1'b0, `OFF_VOLUME, 32'h0, 1'b0, {24'h000000, v[7:0]});
    apb(1'b1, `OFF_STATUS, v, 1'b1, 32'h0);
    apb(1'b1, 12'h020, v, 1'b1, 32'h0);
    apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
    $display("test registers done");
    alive <= 1'b1;
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++)
      begin
        apb(1'b1, `OFF_CTRL, 32'(m), 1'b0, 32'h0);
        recording <= c[0];
        playing   <= c[1];
        repeat (4) @(posedge ref_clk);
        chk("monitor_on", m == 0 ? 32'(c[0]) : m == 2 ? 32'(!c[1]) : 32'h0, 32'(monitor_on));
      end
    apb(1'b0, `OFF_CTRL, 32'h0, 1'b0, 32'h00000042);
    $display("test monitoring done");
    recording <= 1'b0;
    playing   <= 1'b1;
    apb(1'b1, `OFF_CTRL, 32'h00000010, 1'b0, 32'h0);
    frame();
    chk("out_multi", 32'h1, 32'(out_multi));
    chk("out_ch0", 32'(psnap[0]), 32'(out_ch[0]));
    chk("out_ch1", 32'(psnap[1]), 32'(out_ch[1]));
    chk("ana_left", 32'(att(psnap[0], v[7:0])), 32'(ana_left));
    chk("ana_right", 32'(att(psnap[1], v[7:0])), 32'(ana_right));
    playing <= 1'b0;
    apb(1'b1, `OFF_CTRL, 32'h00000012, 1'b0, 32'h0);
    frame();
    chk("out_ch6", 32'(isnap[0]), 32'(out_ch[6]));
    multi <= 1'b1;
    apb(1'b1, `OFF_TRACK, 32'h00000001, 1'b0, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h00000022, 1'b0, 32'h0);
    frame();
    chk("out_multi", 32'h0, 32'(out_multi));
    chk("out_ch0", 32'(isnap[2]), 32'(out_ch[0]));
    chk("rec_left", 32'(isnap[0]), 32'(rec_left));
    $display("test routing done");
    multi <= 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      rate         <= p == 1 ? 17'h17700 : 17'h0BB80;
      play_rate_hz <= p == 2 ? 17'h17700 : 17'h0BB80;
      alive        <= 1'b0;
      apb(1'b1, `OFF_CTRL, 32'h00000004, 1'b0, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h0, 1'b0, 32'h0);
      repeat (8) @(posedge ref_clk);
      wsrc(SRC_CRYSTAL);
      alive <= 1'b1;
      wsrc(SRC_INPUT);
      rate <= 17'h0FDE8;
      repeat (8) @(posedge ref_clk);
      wsrc(SRC_INPUT);
    end
    apb(1'b1, `OFF_CTRL, 32'h00000004, 1'b0, 32'h0);
    repeat (8) @(posedge ref_clk);
    wsrc(SRC_CRYSTAL);
    word_lock <= 1'b1;
    apb(1'b1, `OFF_CTRL, 32'h00000008, 1'b0, 32'h0);
    wsrc(SRC_WORD);
    $display("test clocks done");
    reset_cycle(1'b0);
    complete_run();
  end
endmodule

bind audio_route_clock_select audio_route_chk chk_u (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .boot_format_jumper, .in_is_multi, .recording, .frame_stb, .in_ch, .out_ch, .rec_left,
  .rec_right, .out_multi, .monitor_on, .clk_src);
